//--- design/sfc_ctrl.v
// serial flash host controller: apb register slave and single-line command engine
// assumes an spi mode 0 flash; miso is asynchronous and is synchronised here
`timescale 1ns/100ps
`default_nettype none
`include "sfc_map.vh"

module sfc_ctrl (
    // clock and reset
    input  wire        clock_i,
    input  wire        resetn_i,
    // apb slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    // flash link
    output reg         flash_cs_n_o,
    output reg         flash_sck_o,
    output reg         flash_mosi_o,
    input  wire        flash_miso_i
);

    // ****************************************
    // local constants
    // ****************************************
    localparam [31:0] HALF_W  = `SFC_HALF_CYC;
    localparam [31:0] PH_W    = 2 * `SFC_HALF_CYC - 1;
    localparam [7:0] HALF     = HALF_W[7:0];
    localparam [7:0] PH_LAST  = PH_W[7:0];
    localparam [1:0] ST_IDLE  = 2'd0;
    localparam [1:0] ST_BIT   = 2'd1;
    localparam [1:0] ST_HOLD  = 2'd2;
    localparam [1:0] SEG_HDR  = 2'd0;
    localparam [1:0] SEG_DUM  = 2'd1;
    localparam [1:0] SEG_TX   = 2'd2;
    localparam [1:0] SEG_RX   = 2'd3;

    // ****************************************
    // reset release and input sync
    // ****************************************
    reg rst_s1_q;
    reg rst_n_q;
    reg miso_s1_q;
    reg miso_s2_q;

    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    always @(posedge clock_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            miso_s1_q <= 1'b0;
            miso_s2_q <= 1'b0;
        end else begin
            miso_s1_q <= flash_miso_i;
            miso_s2_q <= miso_s1_q;
        end
    end

    // ****************************************
    // state
    // ****************************************
    reg [7:0]  op_q;
    reg [3:0]  rxn_q;
    reg [3:0]  txn_q;
    reg        mode_en_q;
    reg [31:0] addr_q;
    reg [3:0]  dummy_q;
    reg        ext_q;
    reg        done_q;
    reg [31:0] tx0_q;
    reg [31:0] tx1_q;
    reg [1:0]  state_q;
    reg [1:0]  seg_q;
    reg [6:0]  bitcnt_q;
    reg [7:0]  ph_q;
    reg [39:0] hdr_sh_q;
    reg [7:0]  dum_sh_q;
    reg [63:0] tx_sh_q;
    reg [63:0] rx_sh_q;
    reg [3:0]  dum_n_q;
    reg [6:0]  tx_bits_q;
    reg [6:0]  rx_bits_q;

    // ****************************************
    // address length per opcode
    // ****************************************
    function [2:0] addr_len;
        input [7:0] op;
        input       ext;
        begin
            case (op)
                `SFC_OP_NREAD,
                `SFC_OP_FREAD,
                `SFC_OP_DYN_RD, `SFC_OP_DYN_WR,
                `SFC_OP_PER_RD, `SFC_OP_PER_PG:
                    addr_len = ext ? 3'd4 : 3'd3;
                `SFC_OP_NREAD4, `SFC_OP_FREAD4,
                `SFC_OP_DYN_RD4, `SFC_OP_DYN_WR4,
                `SFC_OP_PER_RD4, `SFC_OP_PER_PG4:
                    addr_len = 3'd4;
                // byte-only commands: lengths from tx/rx counts
                default: addr_len = 3'd0;
            endcase
        end
    endfunction

    wire [2:0]  go_alen = addr_len(pwdata_i[7:0], ext_q);
    wire        go_fast = (pwdata_i[7:0] == `SFC_OP_FREAD) ||
                          (pwdata_i[7:0] == `SFC_OP_FREAD4);
    wire [39:0] go_hdr  = (go_alen == 3'd4) ? {pwdata_i[7:0], addr_q} :
                          {pwdata_i[7:0], addr_q[23:0], 8'h00};

    // ****************************************
    // apb decode
    // ****************************************
    wire acc_en   = psel_i & penable_i & ~pready_o;
    wire acc_done = psel_i & penable_i & pready_o;
    wire wr_en    = acc_done & pwrite_i;
    wire mapped   = (paddr_i[1:0] == 2'b00) && (paddr_i[7:5] == 3'b000);
    wire go       = wr_en && (paddr_i == `SFC_OFS_CTRL) &&
                    pwdata_i[`SFC_CTRL_GO_BIT] && (state_q == ST_IDLE);
    wire finish   = (state_q == ST_HOLD) && (ph_q == HALF - 8'd1);

    reg [31:0] rd_mux;
    always @* begin
        case (paddr_i)
            `SFC_OFS_CTRL:   rd_mux = {15'h0000, mode_en_q, txn_q, rxn_q, op_q};
            `SFC_OFS_ADDR:   rd_mux = addr_q;
            `SFC_OFS_CFG:    rd_mux = {23'h000000, ext_q, 4'h0, dummy_q};
            `SFC_OFS_STATUS: rd_mux = {30'h00000000, done_q, state_q != ST_IDLE};
            `SFC_OFS_TX0:    rd_mux = tx0_q;
            `SFC_OFS_TX1:    rd_mux = tx1_q;
            `SFC_OFS_RX0:    rd_mux = rx_sh_q[31:0];
            `SFC_OFS_RX1:    rd_mux = rx_sh_q[63:32];
            default:         rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge clock_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            prdata_o  <= 32'h00000000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= acc_en;
            pslverr_o <= acc_en & ~mapped;
            if (acc_en) begin
                prdata_o <= rd_mux;
            end
        end
    end

    // ****************************************
    // next segment after the current one ends
    // ****************************************
    reg [1:0] nxt_seg;
    reg [6:0] nxt_cnt;
    reg       nxt_end;
    always @* begin
        nxt_seg = SEG_RX;
        nxt_cnt = rx_bits_q;
        nxt_end = 1'b0;
        if ((seg_q == SEG_HDR) && (dum_n_q != 4'h0)) begin
            nxt_seg = SEG_DUM;
            nxt_cnt = {3'b000, dum_n_q};
        end else if ((seg_q != SEG_TX) && (seg_q != SEG_RX) && (tx_bits_q != 7'd0)) begin
            nxt_seg = SEG_TX;
            nxt_cnt = tx_bits_q;
        end else if ((seg_q == SEG_RX) || (rx_bits_q == 7'd0)) begin
            nxt_end = 1'b1;
        end
    end

    // ****************************************
    // registers and command engine
    // ****************************************
    always @(posedge clock_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            op_q         <= 8'h00;
            rxn_q        <= 4'h0;
            txn_q        <= 4'h0;
            mode_en_q    <= 1'b0;
            addr_q       <= 32'h00000000;
            dummy_q      <= `SFC_RST_DUMMY;
            ext_q        <= `SFC_RST_EXT;
            done_q       <= 1'b0;
            tx0_q        <= 32'h00000000;
            tx1_q        <= 32'h00000000;
            state_q      <= ST_IDLE;
            seg_q        <= SEG_HDR;
            bitcnt_q     <= 7'd0;
            ph_q         <= 8'h00;
            hdr_sh_q     <= 40'h0000000000;
            dum_sh_q     <= 8'h00;
            tx_sh_q      <= 64'h0000000000000000;
            rx_sh_q      <= 64'h0000000000000000;
            dum_n_q      <= 4'h0;
            tx_bits_q    <= 7'd0;
            rx_bits_q    <= 7'd0;
            flash_cs_n_o <= 1'b1;
            flash_sck_o  <= 1'b0;
            flash_mosi_o <= 1'b0;
        end else begin
            if (wr_en && (paddr_i == `SFC_OFS_ADDR)) begin
                addr_q <= pwdata_i;
            end
            if (wr_en && (paddr_i == `SFC_OFS_CFG)) begin
                dummy_q <= pwdata_i[`SFC_CFG_DUM_LSB +: 4];
                ext_q   <= pwdata_i[`SFC_CFG_EXT_BIT];
            end
            if (wr_en && (paddr_i == `SFC_OFS_TX0)) begin
                tx0_q <= pwdata_i;
            end
            if (wr_en && (paddr_i == `SFC_OFS_TX1)) begin
                tx1_q <= pwdata_i;
            end
            // done is sticky; a finish in the clearing cycle wins
            if (finish) begin
                done_q <= 1'b1;
            end else if (wr_en && (paddr_i == `SFC_OFS_STATUS) &&
                         pwdata_i[`SFC_ST_DONE_BIT]) begin
                done_q <= 1'b0;
            end
            if (go) begin
                op_q      <= pwdata_i[`SFC_CTRL_OP_LSB +: 8];
                rxn_q     <= pwdata_i[`SFC_CTRL_RXN_LSB +: 4];
                txn_q     <= pwdata_i[`SFC_CTRL_TXN_LSB +: 4];
                mode_en_q <= pwdata_i[`SFC_CTRL_MODE_BIT];
                hdr_sh_q  <= go_hdr;
                dum_sh_q  <= pwdata_i[`SFC_CTRL_MODE_BIT] ? `SFC_MODE_BYTE : 8'h00;
                tx_sh_q   <= {tx0_q, tx1_q};
                dum_n_q   <= go_fast ? dummy_q : 4'h0;
                tx_bits_q <= {pwdata_i[`SFC_CTRL_TXN_LSB +: 4], 3'b000};
                rx_bits_q <= {pwdata_i[`SFC_CTRL_RXN_LSB +: 4], 3'b000};
                seg_q     <= SEG_HDR;
                bitcnt_q  <= {1'b0, go_alen, 3'b000} + 7'd8;
                ph_q      <= 8'h00;
                state_q   <= ST_BIT;
                flash_cs_n_o <= 1'b0;
            end
            case (state_q)
                ST_IDLE: begin
                    flash_sck_o <= 1'b0;
                end
                ST_BIT: begin
                    ph_q <= (ph_q == PH_LAST) ? 8'h00 : ph_q + 8'd1;
                    // drive on the low half, device samples on the rise
                    if (ph_q == 8'h00) begin
                        case (seg_q)
                            SEG_HDR: flash_mosi_o <= hdr_sh_q[39];
                            SEG_DUM: flash_mosi_o <= dum_sh_q[7];
                            SEG_TX:  flash_mosi_o <= tx_sh_q[63];
                            default: flash_mosi_o <= 1'b0;
                        endcase
                    end
                    if (ph_q == HALF - 8'd1) begin
                        flash_sck_o <= 1'b1;
                    end
                    // sample late in the high half, after the device's falling-edge drive
                    if (ph_q == PH_LAST) begin
                        flash_sck_o <= 1'b0;
                        case (seg_q)
                            SEG_HDR: hdr_sh_q <= {hdr_sh_q[38:0], 1'b0};
                            SEG_DUM: dum_sh_q <= {dum_sh_q[6:0], 1'b0};
                            SEG_TX:  tx_sh_q  <= {tx_sh_q[62:0], 1'b0};
                            default: rx_sh_q  <= {rx_sh_q[62:0], miso_s2_q};
                        endcase
                        if (bitcnt_q == 7'd1) begin
                            seg_q    <= nxt_seg;
                            bitcnt_q <= nxt_cnt;
                            if (nxt_end) begin
                                state_q <= ST_HOLD;
                            end
                        end else begin
                            bitcnt_q <= bitcnt_q - 7'd1;
                        end
                    end
                end
                ST_HOLD: begin
                    ph_q <= ph_q + 8'd1;
                    if (finish) begin
                        flash_cs_n_o <= 1'b1;
                        state_q      <= ST_IDLE;
                        if (op_q == `SFC_OP_ENTER4) begin
                            ext_q <= 1'b1;
                        end else if (op_q == `SFC_OP_EXIT4) begin
                            ext_q <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // sfc_ctrl

`default_nettype wire

//--- design/sfc_map.vh
// constants of the serial flash command controller: apb offsets, fields, opcodes, timing
// assumes a 20 MHz system clock and one single-line flash on the link
`ifndef SFC_MAP_VH
`define SFC_MAP_VH
// apb register byte offsets
`define SFC_OFS_CTRL      8'h00
`define SFC_OFS_ADDR      8'h04
`define SFC_OFS_CFG       8'h08
`define SFC_OFS_STATUS    8'h0C
`define SFC_OFS_TX0       8'h10
`define SFC_OFS_TX1       8'h14
`define SFC_OFS_RX0       8'h18
`define SFC_OFS_RX1       8'h1C
// field positions
`define SFC_CTRL_OP_LSB   0
`define SFC_CTRL_RXN_LSB  8
`define SFC_CTRL_TXN_LSB  12
`define SFC_CTRL_MODE_BIT 16
`define SFC_CTRL_GO_BIT   31
`define SFC_CFG_DUM_LSB   0
`define SFC_CFG_EXT_BIT   8
`define SFC_ST_BUSY_BIT   0
`define SFC_ST_DONE_BIT   1
// reset values and the mode byte
`define SFC_RST_DUMMY     4'h8
`define SFC_RST_EXT       1'b0
`define SFC_MODE_BYTE     8'hA0
// opcodes
`define SFC_OP_NREAD      8'h03
`define SFC_OP_NREAD4     8'h13
`define SFC_OP_FREAD      8'h0B
`define SFC_OP_FREAD4     8'h0C
`define SFC_OP_ENTER4     8'hB7
`define SFC_OP_EXIT4      8'h29
`define SFC_OP_DYN_RD     8'hFA
`define SFC_OP_DYN_WR     8'hFB
`define SFC_OP_DYN_RD4    8'hE0
`define SFC_OP_DYN_WR4    8'hE1
`define SFC_OP_PER_RD     8'hFC
`define SFC_OP_PER_RD4    8'hE2
`define SFC_OP_PER_PG     8'hFD
`define SFC_OP_PER_PG4    8'hE3
// timing: serial clock half period in system cycles
`define SFC_CLK_PERIOD_NS 50
`define SFC_SCK_MIN_NS    400
`define SFC_HALF_CYC      (`SFC_SCK_MIN_NS / (2 * `SFC_CLK_PERIOD_NS))
`endif

//--- verif/sfc_ctrl_assertions.sv
// checker of the apb slave timing and the flash link pins of sfc_ctrl
// assumes the port names of sfc_ctrl; attached by the bind at the foot
`timescale 1ns/100ps
`default_nettype none
module sfc_ctrl_chk (
    // clock and reset
    input wire logic        clock_i,
    input wire logic        resetn_i,
    // apb
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // flash link
    input wire logic        flash_cs_n_o,
    input wire logic        flash_sck_o,
    input wire logic        flash_mosi_o
);
    // ************************************************************
    // properties
    // ************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    sequence s_bit_high;
        flash_sck_o [*4] ##1 !flash_sck_o;
    endsequence
    sequence s_lead_in;
        !flash_sck_o [*4];
    endsequence

    a_apb_one_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("apb answer not one wait state");
    a_ready_single: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    a_ready_cause: assert property (pready_o |-> $past(psel_i) && $past(penable_i))
        else $error("pready without access phase");
    a_err_zero_data: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
        else $error("error answer malformed");
    a_sck_idle_low: assert property (flash_cs_n_o |-> !flash_sck_o)
        else $error("serial clock moves while deselected");
    a_bit_high_four: assert property ($rose(flash_sck_o) |-> s_bit_high)
        else $error("serial clock high phase wrong");
    a_mosi_held: assert property (flash_sck_o |-> $stable(flash_mosi_o) && !flash_cs_n_o)
        else $error("data changes while clock high");
    a_select_lead: assert property ($fell(flash_cs_n_o) |-> s_lead_in)
        else $error("clock too soon after select");
    a_select_trail: assert property ($rose(flash_cs_n_o) |->
        !$past(flash_sck_o, 1) && !$past(flash_sck_o, 3))
        else $error("deselect too soon after clock");
endmodule // sfc_ctrl_chk

bind sfc_ctrl sfc_ctrl_chk u_chk (.clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .flash_cs_n_o(flash_cs_n_o), .flash_sck_o(flash_sck_o), .flash_mosi_o(flash_mosi_o));
`default_nettype wire

//--- verif/sfc_flash_model.sv
// behavioural single-line flash: read array, address modes, protection command capture
// assumes spi mode 0 from the host; test hooks give busy state and dummy count
`timescale 1ns/100ps
`default_nettype none
module sfc_flash_model (
    // link pins
    input  wire logic        cs_n_i,
    input  wire logic        sck_i,
    input  wire logic        mosi_i,
    output logic             miso_o,
    // test hooks
    input  wire logic        wip_i,
    input  wire logic [3:0]  dummy_i,
    output logic             ext_o,
    output logic [7:0]       cmd_o,
    output logic [31:0]      addr_o,
    output logic [7:0]       wbyte_o
);
    // ************************************************************
    // command decoder
    // ************************************************************
    integer      nb = 0;
    integer      na, hdr, k;
    logic [7:0]  sr, wb, mb;
    logic [23:0] ra;
    logic        live, rdc;

    initial begin
        {ext_o, miso_o, cmd_o, addr_o, wbyte_o} = '0;
    end
    always @* begin
        case (cmd_o)
            8'h03, 8'h0B, 8'hFA, 8'hFB, 8'hFC, 8'hFD: na = ext_o ? 4 : 3;
            8'h13, 8'h0C, 8'hE0, 8'hE1, 8'hE2, 8'hE3: na = 4;
            default: na = 0;
        endcase
        hdr = 8 + 8 * na + ((cmd_o == 8'h0B || cmd_o == 8'h0C) ? dummy_i : 0);
        rdc = cmd_o == 8'h03 || cmd_o == 8'h13 || cmd_o == 8'h0B || cmd_o == 8'h0C;
    end
    // busy state judged once per frame
    always @(negedge cs_n_i) begin
        nb = 0;
        addr_o = 32'h0;
        live = !wip_i;
    end
    always @(posedge cs_n_i) begin
        if (nb == 8 && cmd_o == 8'hB7) ext_o = 1'b1;
        if (nb == 8 && cmd_o == 8'h29) ext_o = 1'b0;
        miso_o = ~miso_o;
    end
    always @(posedge sck_i) if (!cs_n_i) begin
        if (nb < 8) begin
            sr = {sr[6:0], mosi_i};
            if (nb == 7) cmd_o = sr;
        end else if (nb < 8 + 8 * na) begin
            addr_o = {8'h00, addr_o[22:0], mosi_i};
        end else if (nb >= hdr && nb < hdr + 8) begin
            wb = {wb[6:0], mosi_i};
            if (nb == hdr + 7) wbyte_o = wb;
        end
        nb = nb + 1; // later input bits unused
    end
    // released line shows a changing pattern
    always @(negedge sck_i) if (!cs_n_i) begin
        k = nb - hdr;
        ra = addr_o[23:0] + k[26:3];
        mb = ra[7:0] ^ ra[15:8] ^ ra[23:16] ^ 8'h3C;
        if (live && rdc && k >= 0) miso_o = mb[7 - k % 8];
        else miso_o = ~miso_o;
    end
endmodule // sfc_flash_model
`default_nettype wire

//--- verif/tb_sfc_ctrl.sv
// self-checking bench of sfc_ctrl: apb register access, reads and protection commands
// assumes sfc_map.vh on the include path and the flash model beside the design
`timescale 1ns/100ps
`default_nettype none
`include "sfc_map.vh"
module tb_sfc_ctrl;
    // ************************************************************
    // stimulus and checks
    // ************************************************************
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        write_in_progress = 1'b0, rerr, pready, pslverr, cs_n, sck, mosi, miso, ext;
    logic [7:0]  paddr = 8'h00, cmd, wbyte;
    logic [31:0] pwdata = 32'h0, rdata, prdata, faddr;
    logic [3:0]  dummy = 4'h8;
    integer      fail_count = 0, check_count = 0, i, e;
    logic [19:0] tbl [22] = '{20'h16100, 20'h17010, 20'h18010, 20'hFA101, 20'hFB011, 20'hE0101,
        20'hE1011, 20'hFC101, 20'hE2101, 20'hFD001, 20'hE3001, 20'hE4000, 20'h2B200, 20'h2F020,
        20'hE7800, 20'hE8080, 20'hE9080, 20'hA7100, 20'hA6010, 20'h91000, 20'h7E000, 20'h98000};
    logic [7:0]  rop [4] = '{8'h03, 8'h13, 8'h0B, 8'h0C};
    logic [31:0] radr [4] = '{32'h00FFFFFE, 32'hAB000010, 32'h00000123, 32'h00FFFFFC};

    always #25 clk = ~clk;

    sfc_ctrl dut (.clock_i(clk), .resetn_i(rst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .flash_cs_n_o(cs_n), .flash_sck_o(sck),
        .flash_mosi_o(mosi), .flash_miso_i(miso));
    sfc_flash_model u_flash (.cs_n_i(cs_n), .sck_i(sck), .mosi_i(mosi), .miso_o(miso),
        .wip_i(write_in_progress), .dummy_i(dummy), .ext_o(ext), .cmd_o(cmd), .addr_o(faddr), .wbyte_o(wbyte));

    // four stored bytes from a, first byte on top
    function automatic [31:0] word4(input logic [23:0] a);
        logic [23:0] b;
        for (int j = 0; j < 4; j++) begin
            b = a + j;
            word4 = {word4[23:0], b[7:0] ^ b[15:8] ^ b[23:16] ^ 8'h3C};
        end
    endfunction
    task tally_and_finish;
        if (fail_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer n;
        @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin fail_count++; tally_and_finish; end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task run(input logic [7:0] op, input logic [3:0] rx, input logic [3:0] tx, input logic md);
        integer n;
        apb(1'b1, `SFC_OFS_CTRL, {1'b1, 14'h0, md, tx, rx, op});
        n = 0;
        do begin apb(1'b0, `SFC_OFS_STATUS, 32'h0); n++; end while (rdata[1] !== 1'b1 && n < 500);
        if (rdata[1] !== 1'b1) begin fail_count++; tally_and_finish; end
        apb(1'b1, `SFC_OFS_STATUS, 32'h2);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b0, `SFC_OFS_CFG, 32'h0); chk(rdata, 32'h8);
        apb(1'b0, `SFC_OFS_STATUS, 32'h0); chk(rdata, 32'h0);
        apb(1'b1, 8'h20, 32'h1); chk(rerr, 1);
        apb(1'b0, 8'h22, 32'h0); chk(rdata, 32'h0);
        write_in_progress <= 1'b1;
        for (i = 0; i < 3; i = i + 2) begin
            run(rop[i], 4'h8, 4'h0, 1'b0);
            apb(1'b0, `SFC_OFS_RX1, 32'h0);
            chk(rdata == 32'hAAAAAAAA || rdata == 32'h55555555, 1);
        end
        write_in_progress <= 1'b0;
        for (e = 0; e < 2; e++) begin
            if (e == 1) begin
                run(8'hB7, 4'h0, 4'h0, 1'b0);
                apb(1'b0, `SFC_OFS_CFG, 32'h0); chk(rdata, 32'h108);
                chk(ext, 1);
            end
            for (i = 0; i < 4; i++) begin
                dummy = (i == 2) ? 4'h4 : 4'h8;
                apb(1'b1, `SFC_OFS_CFG, {23'h0, e[0], 4'h0, dummy});
                apb(1'b1, `SFC_OFS_ADDR, radr[i]);
                run(rop[i], 4'h8, 4'h0, i == 3);
                apb(1'b0, `SFC_OFS_RX1, 32'h0); chk(rdata, word4(radr[i][23:0]));
                apb(1'b0, `SFC_OFS_RX0, 32'h0); chk(rdata, word4(radr[i][23:0] + 24'd4));
            end
        end
        apb(1'b0, `SFC_OFS_CTRL, 32'h0); chk(rdata, 32'h0001080C);
        apb(1'b0, `SFC_OFS_ADDR, 32'h0); chk(rdata, 32'h00FFFFFC);
        run(8'h29, 4'h0, 4'h0, 1'b0);
        apb(1'b0, `SFC_OFS_CFG, 32'h0); chk(rdata, 32'h8);
        chk(ext, 0);
        for (i = 0; i < 22; i++) begin
            apb(1'b1, `SFC_OFS_TX0, {i[7:0] + 8'h40, 24'h0});
            apb(1'b1, `SFC_OFS_ADDR, 32'h12345678);
            run(tbl[i][19:12], tbl[i][11:8], tbl[i][7:4], 1'b0);
            chk(cmd, tbl[i][19:12]);
            chk(faddr, tbl[i][0] ? 32'h00345678 : 32'h0);
            if (tbl[i][7:4] != 4'h0) chk(wbyte, i[7:0] + 8'h40);
        end
        tally_and_finish;
    end
endmodule // tb_sfc_ctrl
`default_nettype wire
